// ### rtl/pmb_bank_select.sv
// Program memory paging with page register and six entry return stack
//
// Functional notes
// - Six entry twelve bit stack holds pushed return addresses only, not the current PC.
// - Program counter is twelve bits, reaching a 4K window directly.
// - Physical program memory is 2K banks, up to 16K bytes total.
// - Lower window fetches use page code last written at data address CAh.
// - Upper 2K of the window always maps to the fixed static page.
// - Page 1 and the static page reach the same physical locations.
// - Three low page bits give pages 0 to 7; PC bit 11 forces static.
// - Page register is write only; software sets it before switched fetch.
`timescale 1ns/10ps
`default_nettype none
`include "pmb_map.svh"

module pmb_bank_select
    import pmb_pkg::*;
#(
    parameter int STACK_DEPTH = `PMB_STACK_DEPTH
) (
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    input  wire logic          data_wr_en,
    input  wire logic [7:0]    data_wr_addr,
    input  wire logic [7:0]    data_wr_data,
    input  wire logic          fetch_valid,
    input  wire pmb_pc_t       fetch_pc,
    input  wire pmb_stack_op_e stack_op,
    input  wire pmb_pc_t       stack_push_data,
    output logic               prog_rd_en,
    output pmb_phys_t          prog_addr,
    output pmb_pc_t            stack_top,
    output logic [2:0]         stack_level,
    output logic               stack_full,
    output logic               stack_empty
);

    // ************************************************************
    // Assertion clock
    // ************************************************************
    default clocking ast_clk @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ************************************************************
    // Page register
    // ************************************************************
    pmb_page_t page_code_bits;
    wire       page_wr;
    wire       fetch_upper_half_bit;
    pmb_page_t fetch_page;
    pmb_phys_t next_prog_addr;

    // Write only, no read path
    assign page_wr = data_wr_en && (data_wr_addr == `PMB_PAGE_SEL_ADDR);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            page_code_bits <= `PMB_PAGE_SEL_RESET;
        end else if (page_wr) begin
            page_code_bits <= data_wr_data[`PMB_PAGE_CODE_MSB:0];
        end
    end

    // ************************************************************
    // Fetch address formation
    // ************************************************************
    function automatic pmb_phys_t map_fetch(input pmb_pc_t pc,
                                            input pmb_page_t pg);
        pmb_page_t sel;
        sel = pc[`PMB_UPPER_HALF_BIT] ? `PMB_STATIC_PAGE : pg;
        return {sel, pc[`PMB_UPPER_HALF_BIT-1:0]};
    endfunction

    assign fetch_upper_half_bit = fetch_pc[`PMB_UPPER_HALF_BIT];
    assign fetch_page = fetch_upper_half_bit ? `PMB_STATIC_PAGE
                                             : page_code_bits;
    assign next_prog_addr = map_fetch(fetch_pc, page_code_bits);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prog_rd_en <= 1'b0;
            prog_addr  <= '0;
        end else begin
            prog_rd_en <= fetch_valid;
            if (fetch_valid) begin
                prog_addr <= next_prog_addr;
            end
        end
    end

    // ************************************************************
    // Return stack
    // ************************************************************
    pmb_pc_t    stack_mem [STACK_DEPTH];
    logic [2:0] next_level;
    wire        do_push;
    wire        do_pop;

    // Push on full drops the oldest entry, pop on empty is ignored
    assign do_push = (stack_op == PMB_OP_PUSH);
    assign do_pop  = (stack_op == PMB_OP_POP) && (stack_level != 3'h0);
    assign next_level = do_push ? ((stack_level == 3'(STACK_DEPTH)) ?
                                   stack_level : stack_level + 3'h1)
                      : do_pop  ? stack_level - 3'h1
                      : stack_level;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= '0;
            end
        end else if (do_push) begin
            stack_mem[0] <= stack_push_data;
            for (int i = 1; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= stack_mem[i-1];
            end
        end else if (do_pop) begin
            for (int i = 0; i < STACK_DEPTH-1; i++) begin
                stack_mem[i] <= stack_mem[i+1];
            end
            stack_mem[STACK_DEPTH-1] <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stack_level <= 3'h0;
            stack_top   <= '0;
            stack_full  <= 1'b0;
            stack_empty <= 1'b1;
        end else begin
            stack_level <= next_level;
            stack_full  <= (next_level == 3'(STACK_DEPTH));
            stack_empty <= (next_level == 3'h0);
            if (do_push) begin
                stack_top <= stack_push_data;
            end else if (do_pop) begin
                stack_top <= stack_mem[1];
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_UPPER_STATIC: assert property (
        fetch_valid && fetch_pc[11] |=> prog_addr[13:11] == 3'h1)
        else $error("upper half fetch not on static page");

    AST_LOWER_PAGE: assert property (
        fetch_valid && !fetch_pc[11] |=>
        prog_addr[13:11] == $past(page_code_bits))
        else $error("lower half fetch not on selected page");

    AST_LOW_BITS: assert property (
        fetch_valid |=> prog_addr[10:0] == $past(fetch_pc[10:0]))
        else $error("low fetch bits not carried through");

    AST_PAGE_WRITE: assert property (
        data_wr_en && data_wr_addr == 8'hca ##1 fetch_valid && !fetch_pc[11]
        |=> prog_addr[13:11] == $past(data_wr_data[2:0], 2))
        else $error("new page code not applied to next fetch");

    AST_PAGE_HOLD: assert property (
        !(data_wr_en && data_wr_addr == 8'hca) |=> $stable(page_code_bits))
        else $error("page register changed without write");

    AST_PAGE1_SAME: assert property (
        fetch_valid && fetch_page == 3'h1 |=> prog_addr[13:11] == 3'h1)
        else $error("page 1 and static page differ");

    AST_PUSH_POP: assert property (
        stack_op == PMB_OP_PUSH ##1 stack_op == PMB_OP_POP |=>
        stack_top == $past(stack_top, 2))
        else $error("stack pop did not restore previous top");

    AST_LEVEL_MAX: assert property (
        stack_level <= 3'(STACK_DEPTH) &&
        stack_full == (stack_level == 3'(STACK_DEPTH)))
        else $error("stack level out of range");

    AST_EMPTY_FLAG: assert property (
        stack_empty == (stack_level == 3'h0))
        else $error("empty flag does not match level");

    AST_PUSH_TOP: assert property (
        stack_op == PMB_OP_PUSH |=> stack_top == $past(stack_push_data))
        else $error("pushed address not on top");

    AST_FULL_PUSH: assert property (
        stack_op == PMB_OP_PUSH && stack_full |=>
        stack_full && stack_level == 3'(STACK_DEPTH))
        else $error("push on full stack changed level");

    AST_POP_EMPTY: assert property (
        stack_op == PMB_OP_POP && stack_empty |=>
        stack_empty && stack_top == '0)
        else $error("pop on empty stack not ignored");

    AST_STACK_IDLE: assert property (
        stack_op == PMB_OP_NONE |=>
        $stable(stack_top) && $stable(stack_level))
        else $error("stack changed without request");

    AST_RD_EN: assert property (
        fetch_valid |=> prog_rd_en)
        else $error("fetch not issued");

    AST_RD_IDLE: assert property (
        !fetch_valid |=> !prog_rd_en && $stable(prog_addr))
        else $error("fetch output moved without request");

    // ************************************************************
    // Coverage of the main scenarios
    // ************************************************************
    COV_UPPER: cover property (fetch_valid && fetch_pc[11]);
    COV_PAGE7: cover property (
        fetch_valid && !fetch_pc[11] && page_code_bits == 3'h7);
    COV_FULL: cover property (stack_full);
    COV_PUSH_POP: cover property (
        stack_op == PMB_OP_PUSH ##1 stack_op == PMB_OP_POP);

endmodule // pmb_bank_select

`default_nettype wire

// ### pkg/pmb_map.svh
// Address map, field positions and sizes of the program memory bank select
`ifndef PMB_MAP_SVH
`define PMB_MAP_SVH

`define PMB_PAGE_SEL_ADDR   8'hca
`define PMB_PAGE_SEL_RESET  3'h0
`define PMB_PAGE_CODE_MSB   2
`define PMB_UPPER_HALF_BIT  11
`define PMB_STATIC_PAGE     3'h1
`define PMB_PC_WIDTH        12
`define PMB_PHYS_WIDTH      14
`define PMB_STACK_DEPTH     6

`endif

// ### pkg/pmb_pkg.sv
// Types shared by the program memory bank select logic
`include "pmb_map.svh"

package pmb_pkg;

    typedef logic [`PMB_PC_WIDTH-1:0]   pmb_pc_t;
    typedef logic [`PMB_PHYS_WIDTH-1:0] pmb_phys_t;
    typedef logic [2:0]                 pmb_page_t;

    typedef enum logic [1:0] {
        PMB_OP_NONE,
        PMB_OP_PUSH,
        PMB_OP_POP
    } pmb_stack_op_e;

endpackage

// ### sim/pmb_core_model.sv
// Core side model: data-space writes, fetches and stack requests
`timescale 1ns/10ps
`default_nettype none

module pmb_core_model
    import pmb_pkg::*;
(
    input  wire logic          sys_clk,
    output var  logic          data_wr_en,
    output var  logic [7:0]    data_wr_addr,
    output var  logic [7:0]    data_wr_data,
    output var  logic          fetch_valid,
    output var  pmb_pc_t       fetch_pc,
    output var  pmb_stack_op_e stack_op,
    output var  pmb_pc_t       stack_push_data
);
    // ****************
    // Request driver
    // ****************
    initial begin
        {data_wr_en, data_wr_addr, data_wr_data} = '0;
        {fetch_valid, fetch_pc, stack_push_data} = '0;
        stack_op = PMB_OP_NONE;
    end

    // One request a cycle; unused write address, write data and fetch PC carry noise
    task automatic req(input logic w, input logic [7:0] a,
        input logic [2:0] p, input logic f, input pmb_pc_t pc,
        input pmb_stack_op_e op, input pmb_pc_t d);
        @(negedge sys_clk);
        data_wr_en = w;
        data_wr_addr = w ? a : 8'($urandom);
        data_wr_data = w ? {5'h00, p} : 8'($urandom);
        fetch_valid = f;
        fetch_pc = f ? pc : 12'($urandom);
        stack_op = op;
        stack_push_data = d;
        @(posedge sys_clk);
    endtask
endmodule // pmb_core_model

`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for program paging and the return stack
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb;
    import pmb_pkg::*;
    logic sys_clk, nrst, data_wr_en, fetch_valid, prog_rd_en;
    logic stack_full, stack_empty;
    logic [7:0] data_wr_addr, data_wr_data;
    logic [2:0] stack_level;
    pmb_pc_t fetch_pc, stack_push_data, stack_top;
    pmb_stack_op_e stack_op;
    pmb_phys_t prog_addr, ex;
    pmb_phys_t exp_q[$];
    pmb_pc_t stk[$];
    pmb_page_t page;
    int n_fail = 0;
    int cmp_count = 0;

    pmb_core_model core (.sys_clk, .data_wr_en, .data_wr_addr,
        .data_wr_data, .fetch_valid, .fetch_pc, .stack_op,
        .stack_push_data);
    pmb_bank_select uut (.sys_clk, .nrst, .data_wr_en, .data_wr_addr,
        .data_wr_data, .fetch_valid, .fetch_pc, .stack_op,
        .stack_push_data, .prog_rd_en, .prog_addr, .stack_top,
        .stack_level, .stack_full, .stack_empty);

    // ****************
    // Tasks and monitor
    // ****************
    task automatic wr(input logic [7:0] a, input pmb_page_t p);
        core.req(1'b1, a, p, 1'b0, '0, PMB_OP_NONE, '0);
        if (a == 8'hca) page = p;
    endtask
    task automatic fe(input pmb_pc_t pc);
        core.req(1'b0, '0, '0, 1'b1, pc, PMB_OP_NONE, '0);
        exp_q.push_back({pc[11] ? 3'h1 : page, pc[10:0]});
    endtask
    task automatic st(input pmb_stack_op_e op);
        int n;
        core.req(1'b0, '0, '0, 1'b0, '0, op, 12'($urandom));
        if (op == PMB_OP_PUSH) stk.push_back(stack_push_data);
        if (stk.size() > 6) void'(stk.pop_front());
        if (op == PMB_OP_POP && stk.size() > 0) void'(stk.pop_back());
        n = stk.size();
        #1;
        `CHK(stack_top, n ? stk[$] : 12'h000)
        `CHK(stack_level, 3'(n))
        `CHK({stack_full, stack_empty}, {n == 6, n == 0})
    endtask
    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(negedge sys_clk) begin
        if (prog_rd_en === 1'b1) begin
            ex = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK(prog_addr, ex)
        end
    end

    // ****************
    // Clock, watchdog, tests
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        #80000;
        n_fail++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        void'($urandom(32'h426e0034));
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) nrst = 1'b1;
        `CHK({prog_rd_en, prog_addr, stack_top}, 27'h0)
        `CHK({stack_level, stack_full, stack_empty}, 5'h01)
        for (int p = 0; p < 8; p++) begin
            wr(8'hca, 3'(p));
            fe({1'b0, 11'($urandom)});
            fe({1'b1, 11'($urandom)});
            fe(12'h0ab);
            fe(12'h8ab);
        end
        wr(8'hc9, 3'h3);
        fe(12'h123);
        repeat (60) begin
            if ($urandom % 3 == 0) wr(8'hc8 + 8'($urandom % 5), 3'($urandom));
            fe(12'($urandom));
        end
        repeat (7) st(PMB_OP_PUSH);
        repeat (7) st(PMB_OP_POP);
        repeat (3) core.req(1'b0, '0, '0, 1'b0, '0, PMB_OP_NONE, '0);
        `CHK(exp_q.size(), 0)
        final_report();
    end
endmodule // tb

`default_nettype wire
